// [common/dmac3_pkg.sv]
package dmac3_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] REG_BASE      = 32'h5000_3630;
  localparam logic [31:0] IDX_SRC_LOW   = 32'h5000_3630;
  localparam logic [31:0] IDX_SRC_HIGH  = 32'h5000_3632;
  localparam logic [31:0] IDX_DST_LOW   = 32'h5000_3634;
  localparam logic [31:0] IDX_DST_HIGH  = 32'h5000_3636;
  localparam logic [31:0] IDX_THRESHOLD = 32'h5000_3638;
  localparam logic [31:0] IDX_LENGTH    = 32'h5000_363a;
  localparam logic [31:0] IDX_CONTROL   = 32'h5000_363c;
  localparam logic [31:0] IDX_ITEM      = 32'h5000_363e;
  localparam int          ADDR_BITS     = 8;

  // ****************************************************************
  // Control word fields
  // ****************************************************************
  localparam int             CTL_ON        = 0;
  localparam int             CTL_WIDTH_LO  = 1;
  localparam int             CTL_IRQ_EN    = 3;
  localparam int             CTL_TRIGGER   = 4;
  localparam int             CTL_DST_INC   = 5;
  localparam int             CTL_SRC_INC   = 6;
  localparam int             CTL_CIRCULAR  = 7;
  localparam int             CTL_PRIO_LO   = 8;
  localparam int             CTL_IDLE      = 11;
  localparam int             CTL_FILL      = 12;
  localparam int             CTL_EDGE      = 13;
  localparam logic [15:0]    CTL_RW_MASK   = 16'h3fff;
  localparam logic [15:0]    REG_RESET     = 16'h0000;
  localparam logic [1:0]     WIDTH_BYTE    = 2'h0;
  localparam logic [1:0]     WIDTH_HALF    = 2'h1;
  localparam logic [1:0]     WIDTH_WORD    = 2'h2;
  localparam int             PEERS         = 3;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ARB   = 5'h02,
    ST_READ  = 5'h04,
    ST_WRITE = 5'h08,
    ST_GAP   = 5'h10
  } dmac3_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  size;
  } dmac3_mem_t;

  typedef struct packed {
    logic [15:0]  src_low;
    logic [15:0]  src_high;
    logic [15:0]  dst_low;
    logic [15:0]  dst_high;
    logic [15:0]  threshold;
    logic [15:0]  length;
    logic [15:0]  control;
    logic [15:0]  item;
    dmac3_state_t state;
    dmac3_mem_t   mem;
    logic [31:0]  data;
    logic         fetched;
    logic         req_q;
    logic         pending;
    logic         bus_req;
    logic         bus_lock;
    logic         irq;
    logic         periph_ack;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } dmac3_regs_t;

endpackage

// [verilog/dmac3_channel.sv]
// What this block does
// - Source start address kept as two writable 16-bit halves, reset zero.
// - Destination start address kept as two writable 16-bit halves, reset zero.
// - After each item, interrupt if threshold equals index and enabled.
// - Moves programmed length plus one items.
// - Bit 13 picks level (0) or rising-edge (1) request sensing.
// - Bit 12 fill mode: one source read written to every destination.
// - Fill mode keeps the bus and is never preempted by other channels, unless bit 11 is set without triggering.
// - Bit 11 clear, untriggered: back-to-back transfers, lower masters locked out.
// - Bit 11 set: one idle cycle after each store; ignored when triggered.
// - Highest 3-bit priority field among requesting channels wins.
// - Equal priority: lowest channel number wins.
// - Bit 7 clear: stop after length and clear on bit.
// - Bit 7 set with triggering: index to zero, restart, stay on.
// - Bit 6 advances source address by width per item, else fixed.
// - Bit 5 advances destination address by width per item, else fixed.
// - Bit 4 clear starts at once; set waits for peripheral request.
// - Bit 3 gates the channel interrupt.
// - Width codes: 00 one byte, 01 two, 10 four, 11 reserved.
// - Bit 0 turns channel on; off halts it; bits 15:14 read zero.
// - Read-only item index counts items, forms addresses, zero at end.
// - Channel three serves the memory-to-peripheral request of its pair.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dmac3_channel
  import dmac3_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 periph_req_tx,
  output logic                      periph_ack,
  input  wire logic [PEERS-1:0]     peer_req,
  input  wire logic [3*PEERS-1:0]   peer_prio,
  output logic                      bus_req,
  output logic                      bus_lock,
  input  wire logic                 bus_gnt,
  output logic                      mem_valid,
  output logic                      mem_write,
  output logic [31:0]               mem_addr,
  output logic [31:0]               mem_wdata,
  output logic [1:0]                mem_size,
  input  wire logic                 mem_ready,
  input  wire logic [31:0]          mem_rdata,
  output logic                      irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [ADDR_BITS-1:0] byte_addr(
    input logic [31:0] idx
  );
    logic [31:0] off;
    off = (idx - REG_BASE) << 2;
    return off[ADDR_BITS-1:0];
  endfunction

  function automatic logic [1:0] width_shift(input logic [1:0] code);
    logic [1:0] s;
    s = 2'h0;
    unique case (code)
      WIDTH_HALF: s = 2'h1;
      WIDTH_WORD: s = 2'h2;
      default:    s = 2'h0;
    endcase
    return s;
  endfunction

  // Reserved width code falls back to single bytes
  function automatic logic [1:0] size_code(input logic [1:0] code);
    logic [1:0] c;
    c = code;
    if (code == 2'h3) begin
      c = WIDTH_BYTE;
    end
    return c;
  endfunction

  function automatic logic [31:0] item_addr(
    input logic [31:0] start,
    input logic        inc,
    input logic [15:0] idx,
    input logic [1:0]  code
  );
    logic [31:0] step;
    step = {16'h0000, idx} << width_shift(code);
    return inc ? start + step : start;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  dmac3_regs_t r_r;
  dmac3_regs_t r_nxt;

  logic              on_bit;
  logic              trig_mode;
  logic              fill_mode;
  logic              hold_bus;
  logic              trig_ok;
  logic              win;
  logic              last_item;
  logic              apb_access;
  logic              apb_commit;
  logic              addr_hit;
  logic [2:0]        my_prio;
  logic [1:0]        width_code;
  logic [31:0]       src_start;
  logic [31:0]       dst_start;
  logic [ADDR_BITS-1:0] offs;

  assign on_bit    = r_r.control[CTL_ON];
  assign trig_mode = r_r.control[CTL_TRIGGER];
  assign fill_mode = r_r.control[CTL_FILL];
  assign my_prio   = r_r.control[CTL_PRIO_LO +: 3];
  assign width_code = r_r.control[CTL_WIDTH_LO +: 2];
  assign src_start = {r_r.src_high, r_r.src_low};
  assign dst_start = {r_r.dst_high, r_r.dst_low};
  assign last_item = (r_r.item == r_r.length);
  assign offs      = paddr[ADDR_BITS-1:0];
  assign apb_access = psel && penable;
  assign apb_commit = apb_access && r_r.pready;

  // Bus held for the whole run in blocking mode, and in fill mode unless bit 11 gaps it
  assign hold_bus  = fill_mode
                     || (!r_r.control[CTL_IDLE] && !trig_mode);

  // Level or latched edge decides whether a beat may start
  assign trig_ok   = !trig_mode
                     || (r_r.control[CTL_EDGE] ? r_r.pending
                                                : r_r.req_q);

  // Lose to any peer with higher or equal priority (higher or equal number)
  always_comb begin
    win = 1'b1;
    for (int i = 0; i < PEERS; i++) begin
      if (peer_req[i] && (peer_prio[3*i +: 3] >= my_prio)) begin
        win = 1'b0;
      end
    end
  end

  always_comb begin
    addr_hit = 1'b1;
    unique case (offs)
      byte_addr(IDX_SRC_LOW),  byte_addr(IDX_SRC_HIGH),
      byte_addr(IDX_DST_LOW),  byte_addr(IDX_DST_HIGH),
      byte_addr(IDX_THRESHOLD), byte_addr(IDX_LENGTH),
      byte_addr(IDX_CONTROL),  byte_addr(IDX_ITEM): addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
    if (paddr[31:ADDR_BITS] != '0) begin
      addr_hit = 1'b0;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_nxt            = r_r;
    r_nxt.irq        = 1'b0;
    r_nxt.periph_ack = 1'b0;

    // Peripheral request capture
    r_nxt.req_q = periph_req_tx;
    if (periph_req_tx && !r_r.req_q) begin
      r_nxt.pending = 1'b1;
    end

    unique case (r_r.state)
      ST_IDLE: begin
        r_nxt.fetched = 1'b0;
        r_nxt.bus_req = 1'b0;
        r_nxt.bus_lock = 1'b0;
        if (on_bit && trig_ok) begin
          r_nxt.state   = ST_ARB;
          r_nxt.bus_req = 1'b1;
        end
      end
      ST_ARB: begin
        if (!on_bit) begin
          r_nxt.state    = ST_IDLE;
          r_nxt.bus_req  = 1'b0;
          r_nxt.bus_lock = 1'b0;
        end else if (trig_ok && ((r_r.bus_lock && hold_bus)
                     || (win && bus_gnt))) begin
          r_nxt.bus_lock = hold_bus;
          if (trig_mode) begin
            r_nxt.periph_ack = 1'b1;
            if (!(periph_req_tx && !r_r.req_q)) begin
              r_nxt.pending = 1'b0;
            end
          end
          r_nxt.mem.size  = size_code(width_code);
          r_nxt.mem.valid = 1'b1;
          if (fill_mode && r_r.fetched) begin
            r_nxt.state     = ST_WRITE;
            r_nxt.mem.write = 1'b1;
            r_nxt.mem.wdata = r_r.data;
            r_nxt.mem.addr  = item_addr(dst_start,
                                r_r.control[CTL_DST_INC], r_r.item,
                                r_r.control[CTL_WIDTH_LO +: 2]);
          end else begin
            r_nxt.state     = ST_READ;
            r_nxt.mem.write = 1'b0;
            r_nxt.mem.addr  = item_addr(src_start,
                                r_r.control[CTL_SRC_INC], r_r.item,
                                r_r.control[CTL_WIDTH_LO +: 2]);
          end
        end
      end
      ST_READ: begin
        if (mem_ready) begin
          r_nxt.data      = mem_rdata;
          r_nxt.fetched   = 1'b1;
          r_nxt.state     = ST_WRITE;
          r_nxt.mem.write = 1'b1;
          r_nxt.mem.wdata = mem_rdata;
          r_nxt.mem.addr  = item_addr(dst_start,
                              r_r.control[CTL_DST_INC], r_r.item,
                              r_r.control[CTL_WIDTH_LO +: 2]);
        end
      end
      ST_WRITE: begin
        if (mem_ready) begin
          r_nxt.mem.valid = 1'b0;
          r_nxt.mem.write = 1'b0;
          // Threshold compared before the index moves
          if (r_r.control[CTL_IRQ_EN]
              && (r_r.threshold == r_r.item)) begin
            r_nxt.irq = 1'b1;
          end
          if (last_item) begin
            r_nxt.item    = 16'h0000;
            r_nxt.fetched = 1'b0;
            if (!(r_r.control[CTL_CIRCULAR] && trig_mode)) begin
              r_nxt.control[CTL_ON] = 1'b0;
            end
          end else begin
            r_nxt.item = r_r.item + 16'h0001;
          end
          if (r_r.control[CTL_IDLE] && !trig_mode) begin
            r_nxt.state    = ST_GAP;
            r_nxt.bus_req  = 1'b0;
            r_nxt.bus_lock = 1'b0;
          end else if (last_item && !(r_r.control[CTL_CIRCULAR]
                       && trig_mode)) begin
            r_nxt.state    = ST_IDLE;
            r_nxt.bus_req  = 1'b0;
            r_nxt.bus_lock = 1'b0;
          end else begin
            r_nxt.state    = ST_ARB;
            if (!hold_bus) begin
              r_nxt.bus_lock = 1'b0;
            end
          end
        end
      end
      ST_GAP: begin
        // One free bus cycle for other masters
        if (on_bit) begin
          r_nxt.state   = ST_ARB;
          r_nxt.bus_req = 1'b1;
        end else begin
          r_nxt.state   = ST_IDLE;
        end
      end
    endcase

    // ****************************************************************
    // APB slave, answer on second access cycle
    // ****************************************************************
    r_nxt.pready  = 1'b0;
    r_nxt.pslverr = 1'b0;
    if (apb_access && !r_r.pready) begin
      r_nxt.pready  = 1'b1;
      r_nxt.pslverr = !addr_hit;
      r_nxt.prdata  = 32'h0000_0000;
      if (!pwrite && addr_hit) begin
        unique case (offs)
          byte_addr(IDX_SRC_LOW):   r_nxt.prdata[15:0] = r_r.src_low;
          byte_addr(IDX_SRC_HIGH):  r_nxt.prdata[15:0] = r_r.src_high;
          byte_addr(IDX_DST_LOW):   r_nxt.prdata[15:0] = r_r.dst_low;
          byte_addr(IDX_DST_HIGH):  r_nxt.prdata[15:0] = r_r.dst_high;
          byte_addr(IDX_THRESHOLD): r_nxt.prdata[15:0] = r_r.threshold;
          byte_addr(IDX_LENGTH):    r_nxt.prdata[15:0] = r_r.length;
          byte_addr(IDX_CONTROL):   r_nxt.prdata[15:0] =
                                      r_r.control & CTL_RW_MASK;
          byte_addr(IDX_ITEM):      r_nxt.prdata[15:0] = r_r.item;
          default:                  r_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (apb_commit && pwrite && !r_r.pslverr) begin
      unique case (offs)
        byte_addr(IDX_SRC_LOW):   r_nxt.src_low   = pwdata[15:0];
        byte_addr(IDX_SRC_HIGH):  r_nxt.src_high  = pwdata[15:0];
        byte_addr(IDX_DST_LOW):   r_nxt.dst_low   = pwdata[15:0];
        byte_addr(IDX_DST_HIGH):  r_nxt.dst_high  = pwdata[15:0];
        byte_addr(IDX_THRESHOLD): r_nxt.threshold = pwdata[15:0];
        byte_addr(IDX_LENGTH):    r_nxt.length    = pwdata[15:0];
        byte_addr(IDX_CONTROL):   r_nxt.control   =
                                    pwdata[15:0] & CTL_RW_MASK;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_r.src_low    <= REG_RESET;
      r_r.src_high   <= REG_RESET;
      r_r.dst_low    <= REG_RESET;
      r_r.dst_high   <= REG_RESET;
      r_r.threshold  <= REG_RESET;
      r_r.length     <= REG_RESET;
      r_r.control    <= REG_RESET;
      r_r.item       <= REG_RESET;
      r_r.state      <= ST_IDLE;
      r_r.mem        <= '0;
      r_r.data       <= 32'h0000_0000;
      r_r.fetched    <= 1'b0;
      r_r.req_q      <= 1'b0;
      r_r.pending    <= 1'b0;
      r_r.bus_req    <= 1'b0;
      r_r.bus_lock   <= 1'b0;
      r_r.irq        <= 1'b0;
      r_r.periph_ack <= 1'b0;
      r_r.pready     <= 1'b0;
      r_r.pslverr    <= 1'b0;
      r_r.prdata     <= 32'h0000_0000;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign pready     = r_r.pready;
  assign prdata     = r_r.prdata;
  assign pslverr    = r_r.pslverr;
  assign periph_ack = r_r.periph_ack;
  assign bus_req    = r_r.bus_req;
  assign bus_lock   = r_r.bus_lock;
  assign mem_valid  = r_r.mem.valid;
  assign mem_write  = r_r.mem.write;
  assign mem_addr   = r_r.mem.addr;
  assign mem_wdata  = r_r.mem.wdata;
  assign mem_size   = r_r.mem.size;
  assign irq        = r_r.irq;

endmodule

`default_nettype wire

// [dv/dmac3_channel_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module dmac3_channel_sva
  import dmac3_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        periph_ack,
  input wire logic        bus_req,
  input wire logic        bus_lock,
  input wire logic        mem_valid,
  input wire logic        mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ready,
  input wire logic        irq
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic store_q;
  always_ff @(posedge clk) begin
    store_q <= !sys_rst && mem_valid && mem_write && mem_ready;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_apb_wait: assert property (s_setup |=> s_answer)
    else $error("pready not in second access cycle");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("error read data not zero");
  a_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid
    && $stable(mem_addr) && $stable(mem_write) && $stable(mem_wdata))
    else $error("memory request changed before ready");
  a_irq_store: assert property (irq |-> store_q)
    else $error("irq not right after a store");
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("irq longer than one cycle");
  a_read_req: assert property ($rose(mem_valid) && !mem_write
    |-> $past(bus_req))
    else $error("read started without bus request");
  a_lock_req: assert property (bus_lock |-> bus_req)
    else $error("bus locked without request");
  a_ack_pulse: assert property (periph_ack |=> !periph_ack)
    else $error("ack longer than one cycle");
  a_ack_beat: assert property (periph_ack |-> ##[0:3] mem_valid)
    else $error("ack without a beat");
endmodule
bind dmac3_channel dmac3_channel_sva i_sva (.clk, .sys_rst, .psel,
  .penable, .pready, .prdata, .pslverr, .periph_ack, .bus_req, .bus_lock,
  .mem_valid, .mem_write, .mem_addr, .mem_wdata, .mem_ready, .irq);
`default_nettype wire

// [dv/dmac3_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dmac3_mem_model
  import dmac3_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        mem_valid,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  mem_size,
  input  wire logic        bus_req,
  output logic             bus_gnt,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata
);
  // ****************************************************************
  // Memory and arbiter with logs
  // ****************************************************************
  logic [31:0] wa [256];
  logic [31:0] wd [256];
  logic [1:0]  ws [256];
  logic [31:0] ra [256];
  logic [31:0] rdd [256];
  int          wr_n = 0;
  int          rd_n = 0;
  int          cnt = 0;
  logic [31:0] cyc = 0;
  initial mem_ready = 1'b0;
  initial bus_gnt = 1'b0;
  initial mem_rdata = 32'h0000_0000;
  always @(posedge clk) begin
    cyc <= cyc + 32'h0000_0001;
    bus_gnt <= bus_req && !sys_rst;
    mem_ready <= 1'b0;
    // Idle data keeps changing
    mem_rdata <= cyc ^ 32'h9e37_79b9;
    if (sys_rst || !mem_valid || mem_ready) cnt <= 0;
    else if (cnt < (slow ? 3 : 0)) cnt <= cnt + 1;
    else begin
      mem_ready <= 1'b1;
      if (!mem_write) mem_rdata <= {mem_addr[15:0] ^ 16'hc3c3, mem_addr[15:0]};
    end
    if (mem_valid && mem_ready && mem_write) begin
      wa[wr_n % 256] <= mem_addr;
      wd[wr_n % 256] <= mem_wdata;
      ws[wr_n % 256] <= mem_size;
      wr_n <= wr_n + 1;
    end
    if (mem_valid && mem_ready && !mem_write) begin
      ra[rd_n % 256] <= mem_addr;
      rdd[rd_n % 256] <= mem_rdata;
      rd_n <= rd_n + 1;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_dma_channel_three_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dma_channel_three_regs;
  import dmac3_pkg::*;
  logic               clk = 0;
  logic               sys_rst = 1;
  logic               psel = 0;
  logic               penable = 0;
  logic               pwrite = 0;
  logic [31:0]        paddr = 0;
  logic [31:0]        pwdata = 0;
  logic               periph_req_tx = 0;
  logic [PEERS-1:0]   peer_req = '0;
  logic [3*PEERS-1:0] peer_prio = '0;
  logic               slow = 0;
  logic [31:0]        prdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic               pready, pslverr, periph_ack, bus_req, bus_lock, err;
  logic               bus_gnt, mem_valid, mem_write, mem_ready, irq;
  logic [1:0]         mem_size;
  int                 miscompares = 0;
  int                 check_count = 0;
  int                 irq_n = 0;
  int                 ack_n = 0;
  int                 drop_n = 0;
  int                 lock_n = 0;
  logic               req_d = 0;
  always #50 clk = ~clk;
  always @(posedge clk) irq_n += (irq === 1'b1);
  always @(posedge clk) ack_n += (periph_ack === 1'b1);
  // Bus request drops and cycles with the bus held
  always @(posedge clk) begin
    drop_n += (req_d === 1'b1 && bus_req === 1'b0);
    lock_n += (bus_lock === 1'b1);
    req_d = bus_req;
  end
  dmac3_channel i_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .periph_req_tx, .periph_ack,
    .peer_req, .peer_prio, .bus_req, .bus_lock, .bus_gnt, .mem_valid,
    .mem_write, .mem_addr, .mem_wdata, .mem_size, .mem_ready, .mem_rdata,
    .irq);
  dmac3_mem_model i_mem (.clk, .sys_rst, .slow, .mem_valid, .mem_write,
    .mem_addr, .mem_wdata, .mem_size, .bus_req, .bus_gnt, .mem_ready,
    .mem_rdata);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      miscompares++;
      $display("MISMATCH %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(pready, 1);
  endtask
  function automatic logic [31:0] ba(input logic [31:0] idx);
    return (idx - REG_BASE) << 2;
  endfunction
  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    apb(1'b1, ba(idx), d);
  endtask
  task automatic rdc(input logic [31:0] idx, input logic [31:0] exp);
    apb(1'b0, ba(idx), 0);
    chk(rd, exp);
  endtask
  task automatic run(input logic [15:0] ctl, input int len, input int thr,
                     input bit stall);
    int          bw, br, bi, ba_n, w, nr, n, bd, bl;
    logic [31:0] mk;
    bw = i_mem.wr_n;
    br = i_mem.rd_n;
    bi = irq_n;
    ba_n = ack_n;
    bd = drop_n;
    bl = lock_n;
    w = (ctl[2:1] == 2'h3) ? 1 : 1 << ctl[2:1];
    mk = (w == 4) ? 32'hffff_ffff : (32'h1 << (8 * w)) - 32'h1;
    wr(IDX_SRC_LOW, 32'h0000_1000);
    wr(IDX_SRC_HIGH, 0);
    wr(IDX_DST_LOW, 32'h0000_0100);
    wr(IDX_DST_HIGH, 32'h0000_0002);
    wr(IDX_THRESHOLD, thr);
    wr(IDX_LENGTH, len);
    wr(IDX_CONTROL, ctl | 16'h0001);
    if (stall) begin
      if (peer_req != '0) periph_req_tx <= 1'b1;
      repeat (30) @(posedge clk);
      chk(bus_req, peer_req != '0);
      chkn(i_mem.wr_n - bw, 0);
      periph_req_tx <= 1'b1;
      peer_req <= '0;
    end
    n = 0;
    do begin
      apb(1'b0, ba(IDX_CONTROL), 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    periph_req_tx <= 1'b0;
    chk(rd, ctl & 16'h3ffe);
    nr = ctl[CTL_FILL] ? 1 : len + 1;
    chkn(i_mem.rd_n - br, nr);
    chkn(i_mem.wr_n - bw, len + 1);
    for (n = 0; n <= len; n++) begin
      chk(i_mem.wa[(bw + n) % 256],
          32'h0002_0100 + (ctl[CTL_DST_INC] ? n * w : 0));
      if (n < nr) chk(i_mem.ra[(br + n) % 256],
          32'h0000_1000 + (ctl[CTL_SRC_INC] ? n * w : 0));
      chk(i_mem.wd[(bw + n) % 256] & mk,
          i_mem.rdd[(br + (n < nr ? n : 0)) % 256] & mk);
      chk(i_mem.ws[(bw + n) % 256],
          (ctl[2:1] == 2'h3) ? WIDTH_BYTE : ctl[2:1]);
    end
    chkn(irq_n - bi, (ctl[CTL_IRQ_EN] && thr <= len) ? 1 : 0);
    if (ctl[CTL_TRIGGER]) chkn(ack_n > ba_n, 1);
    chkn(drop_n - bd,
         (ctl[CTL_IDLE] && !ctl[CTL_TRIGGER]) ? len + 1 : 1);
    chkn(lock_n > bl,
         ctl[CTL_FILL] || !(ctl[CTL_IDLE] || ctl[CTL_TRIGGER]));
    rdc(IDX_ITEM, 0);
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #3_000_000;
    miscompares++;
    conclude;
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    int b;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rdc(REG_BASE + 2 * i, 0);
    for (int i = 0; i < 6; i++) begin
      wr(REG_BASE + 2 * i, 32'hbeef_0000 | (16'h1111 * (i + 1)));
      rdc(REG_BASE + 2 * i, 16'h1111 * (i + 1));
    end
    wr(IDX_CONTROL, 32'hffff_fffe);
    rdc(IDX_CONTROL, 32'h0000_3ffe);
    wr(IDX_ITEM, 32'h0000_0055);
    rdc(IDX_ITEM, 0);
    apb(1'b0, 32'h0000_0040, 0);
    chk(err, 1);
    chk(rd, 0);
    slow <= 1'b1;
    run(16'h006c, 2, 1, 0);
    run(16'h0862, 3, 0, 0);
    slow <= 1'b0;
    run(16'h0028, 1, 1, 0);
    run(16'h0046, 1, 0, 0);
    run(16'h102c, 3, 5, 0);
    run(16'h0034, 1, 0, 1);
    run(16'h2034, 0, 0, 1);
    peer_prio <= 9'h003;
    peer_req <= 3'b001;
    run(16'h0324, 0, 0, 1);
    peer_prio <= 9'h1c0;
    peer_req <= 3'b100;
    run(16'h0324, 0, 0, 1);
    peer_prio <= 9'h010;
    peer_req <= 3'b010;
    run(16'h0324, 1, 0, 0);
    peer_req <= '0;
    b = i_mem.wr_n;
    wr(IDX_LENGTH, 1);
    wr(IDX_CONTROL, 32'h0000_00b5);
    periph_req_tx <= 1'b1;
    repeat (80) @(posedge clk);
    rdc(IDX_CONTROL, 32'h0000_00b5);
    chkn(i_mem.wr_n - b > 2, 1);
    wr(IDX_CONTROL, 0);
    periph_req_tx <= 1'b0;
    repeat (20) @(posedge clk);
    conclude;
  end
endmodule
`default_nettype wire
